//--- psrb_pkg.sv
// psrb_pkg: offsets, command codes, status bit layout, configuration memory
// image and CRC helpers shared by the register bank, the host model and the bench.
// assumes byte offsets as seen by the serial frame decoder.
package psrb_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h22;
  localparam logic [ADDR_W-1:0] OFS_TEMP    = 8'h2E;
  localparam logic [ADDR_W-1:0] OFS_PRESS   = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_SNAP    = 8'h32;
  localparam logic [ADDR_W-1:0] OFS_LIVE    = 8'h36;

  // command codes
  localparam logic [DATA_W-1:0] CMD_SLEEP = 16'h6C32;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'hB169;

  // live / snapshot status bit positions
  localparam int BIT_IDLE         = 0;
  localparam int BIT_PRESS_UP     = 3;
  localparam int BIT_TEMP_UP      = 4;
  localparam int BIT_SUPPLY_FAULT = 7;
  localparam int BIT_CHECK_FAULT  = 8;
  localparam int BIT_SATURATED    = 10;
  localparam int BIT_LINK_CRC     = 11;
  localparam int BIT_PRESS_MISS   = 14;
  localparam int BIT_TEMP_MISS    = 15;
  localparam logic [DATA_W-1:0] EVENT_MASK   = 16'hC998;
  localparam logic [DATA_W-1:0] LIVE_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 16'h0000;

  // configuration memory and its check
  localparam int CFG_DEPTH = 8;
  localparam int CFG_W     = $clog2(CFG_DEPTH);
  localparam logic [CFG_W-1:0] CFG_LAST = CFG_W'(CFG_DEPTH - 1);
  localparam logic [7:0] CRC8_POLY = 8'hD5;
  localparam logic [7:0] CRC8_INIT = 8'hFF;

  typedef enum logic [1:0] {
    ST_LOAD  = 2'b00,
    ST_DRAIN = 2'b01,
    ST_RUN   = 2'b10
  } psrb_boot_e;

  function automatic logic [7:0] crc8Byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ CRC8_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // low byte goes first, as on the wire
  function automatic logic [7:0] crc8Word(input logic [7:0] crc, input logic [DATA_W-1:0] w);
    return crc8Byte(crc8Byte(crc, w[7:0]), w[15:8]);
  endfunction

  // default image; last word carries the CRC of all the others
  function automatic logic [CFG_DEPTH*DATA_W-1:0] cfgDefaultImage();
    logic [CFG_DEPTH*DATA_W-1:0] img;
    logic [7:0]                  c;
    img = '0;
    c   = CRC8_INIT;
    for (int i = 0; i < CFG_DEPTH - 1; i++) begin
      img[i*DATA_W +: DATA_W] = 16'h1000 + DATA_W'(i * 16'h0111);
      c = crc8Word(c, img[i*DATA_W +: DATA_W]);
    end
    img[(CFG_DEPTH-1)*DATA_W +: DATA_W] = {8'h00, c};
    return img;
  endfunction

endpackage

//--- psrb_cfg_mem.sv
// psrb_cfg_mem: read-only configuration memory with registered read data.
// assumes the image is fixed at build time; one read per cycle.
`timescale 1ns/10ps
module psrb_cfg_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int AW    = 3,
  parameter logic [DEPTH*WIDTH-1:0] IMAGE = '0
) (
  // clock
  input  wire logic             clk_sys,
  // read port
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] rdData_reg;

  always_ff @(posedge clk_sys) begin
    rdData_reg <= IMAGE[rdAddr*WIDTH +: WIDTH];
  end

  assign rdData = rdData_reg;

endmodule

//--- psrb_regs.sv
// psrb_regs: host-visible register bank of the pressure/temperature sensor.
// assumes regRead/regWrite are one-cycle strobes from the serial frame
// decoder, never both in one cycle; signal-path inputs are synchronous.
// Behaviour
// - registers are reached only through the serial interface register port.
// - after power-up only live status and command registers accept writes.
// - writing 0x6C32 to command offset 0x22 enters sleep.
// - writing 0xB169 to command register resets and reruns power-up.
// - power-up loads configuration memory and checks its CRC.
// - temperature result at 0x2E; each new result sets temperature-updated flag.
// - pressure result at 0x30; each new result sets pressure-updated flag.
// - results are invalid after power-up until their first measurement arrives.
// - on configuration CRC failure results are never updated.
// - reading pressure copies live pressure flag into snapshot bit 3.
// - reading temperature copies live temperature flag into snapshot bit 4.
// - snapshot bits 15:5 and 0 always mirror live status.
// - reading a result clears its live updated flag.
// - event flags other than the updated flags stay set until a one is written to live status.
`timescale 1ns/10ps
module psrb_regs #(
  parameter logic [psrb_pkg::CFG_DEPTH*psrb_pkg::DATA_W-1:0] CFG_IMAGE =
    psrb_pkg::cfgDefaultImage()
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  // register port from the serial frame decoder
  input  wire logic [psrb_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic                          regWrite,
  input  wire logic                          regRead,
  input  wire logic [psrb_pkg::DATA_W-1:0]   regWdata,
  output logic      [psrb_pkg::DATA_W-1:0]   regRdata,
  // measurement path
  input  wire logic                          tempNew,
  input  wire logic [psrb_pkg::DATA_W-1:0]   tempData,
  input  wire logic                          pressNew,
  input  wire logic [psrb_pkg::DATA_W-1:0]   pressData,
  // live conditions and events
  input  wire logic                          chipIdle,
  input  wire logic                          dspSaturated,
  input  wire logic                          bridgeSupplyFault,
  input  wire logic                          bridgeCheckFault,
  input  wire logic                          linkCrcError,
  // device state
  output logic                               sleepMode,
  output logic                               bootDone,
  output logic                               cfgCrcFail,
  output logic                               tempValid,
  output logic                               pressValid,
  // configuration words handed to the signal path
  output logic                               cfgStrobe,
  output logic      [psrb_pkg::CFG_W-1:0]    cfgIndex,
  output logic      [psrb_pkg::DATA_W-1:0]   cfgWord
);
  import psrb_pkg::*;

  localparam int BOOT_CYC = CFG_DEPTH + 1;

  psrb_boot_e        boot_reg, boot_next;
  logic [CFG_W-1:0]  cnt_reg, cnt_next;
  logic [CFG_W-1:0]  dataIdx_reg;
  logic              dataValid_reg;
  logic [7:0]        crc_reg, crc_next;
  logic              crcFail_reg, crcFail_next;
  logic              softReset_reg;
  logic              bootDone_reg;
  logic              sleep_reg;
  logic [DATA_W-1:0] temp_reg, press_reg;
  logic              tempValid_reg, pressValid_reg;
  logic [DATA_W-1:0] liveEvt_reg, liveEvt_next;
  logic              snapPress_reg, snapTemp_reg;
  logic [DATA_W-1:0] rdData_reg;
  logic              cfgStrobe_reg;
  logic [CFG_W-1:0]  cfgIndex_reg;
  logic [DATA_W-1:0] cfgWord_reg;
  logic [DATA_W-1:0] memData;

  // command reset restarts everything except its own strobe
  wire rstAll = reset | softReset_reg;

  psrb_cfg_mem #(
    .DEPTH (CFG_DEPTH),
    .WIDTH (DATA_W),
    .AW    (CFG_W),
    .IMAGE (CFG_IMAGE)
  ) u_cfg_mem (
    .clk_sys (clk_sys),
    .rdAddr  (cnt_reg),
    .rdData  (memData)
  );

  // power-up walk over the configuration memory
  wire loading   = (boot_reg == ST_LOAD);
  wire lastAddr  = (cnt_reg == CFG_LAST);
  wire dataIsCrc = dataValid_reg && (dataIdx_reg == CFG_LAST);
  wire dataIsCfg = dataValid_reg && !dataIsCrc;

  assign cnt_next     = (loading && !lastAddr) ? cnt_reg + 1'b1 : cnt_reg;
  assign boot_next    = (loading && lastAddr) ? ST_DRAIN :
                        ((boot_reg == ST_DRAIN) && dataIsCrc) ? ST_RUN : boot_reg;
  assign crc_next     = dataIsCfg ? crc8Word(crc_reg, memData) : crc_reg;
  assign crcFail_next = dataIsCrc ? (memData[7:0] != crc_reg) : crcFail_reg;

  // results accepted only after a clean check
  wire resultsLive = (boot_reg == ST_RUN) && !crcFail_reg;
  wire tempTake    = tempNew && resultsLive;
  wire pressTake   = pressNew && resultsLive;

  // register port decode; only command and live status are writable
  wire hitCmd    = regWrite && (regAddr == OFS_COMMAND);
  wire hitLiveWr = regWrite && (regAddr == OFS_LIVE);
  wire readTemp  = regRead && (regAddr == OFS_TEMP);
  wire readPress = regRead && (regAddr == OFS_PRESS);
  wire cmdSleep  = hitCmd && (regWdata == CMD_SLEEP);
  wire cmdReset  = hitCmd && (regWdata == CMD_RESET);

  // live status: set wins over both clears
  wire [DATA_W-1:0] liveView = (liveEvt_reg & EVENT_MASK)
                               | (DATA_W'(chipIdle) << BIT_IDLE)
                               | (DATA_W'(dspSaturated) << BIT_SATURATED);
  wire [DATA_W-1:0] writeClr = hitLiveWr ? (regWdata & EVENT_MASK) : '0;
  wire [DATA_W-1:0] readClr  = (DATA_W'(readTemp) << BIT_TEMP_UP)
                               | (DATA_W'(readPress) << BIT_PRESS_UP);
  wire [DATA_W-1:0] setMask  = (DATA_W'(pressTake) << BIT_PRESS_UP)
                               | (DATA_W'(tempTake) << BIT_TEMP_UP)
                               | (DATA_W'(bridgeSupplyFault) << BIT_SUPPLY_FAULT)
                               | (DATA_W'(bridgeCheckFault) << BIT_CHECK_FAULT)
                               | (DATA_W'(linkCrcError) << BIT_LINK_CRC)
                               | (DATA_W'(pressTake && liveEvt_reg[BIT_PRESS_UP])
                                  << BIT_PRESS_MISS)
                               | (DATA_W'(tempTake && liveEvt_reg[BIT_TEMP_UP])
                                  << BIT_TEMP_MISS);
  assign liveEvt_next = (liveEvt_reg & ~writeClr & ~readClr) | setMask;

  wire [DATA_W-1:0] snapView = {liveView[15:5], snapTemp_reg, snapPress_reg,
                                liveView[2:0]};

  // command register is write-only and reads back as unmapped
  wire [DATA_W-1:0] rdNext = (regAddr == OFS_TEMP)  ? temp_reg  :
                             (regAddr == OFS_PRESS) ? press_reg :
                             (regAddr == OFS_SNAP)  ? snapView  :
                             (regAddr == OFS_LIVE)  ? liveView  : READ_UNMAPPED;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      softReset_reg <= 1'b0;
    end else begin
      softReset_reg <= cmdReset && !softReset_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rstAll) begin
      boot_reg      <= ST_LOAD;
      bootDone_reg  <= 1'b0;
      cnt_reg       <= '0;
      dataValid_reg <= 1'b0;
      dataIdx_reg   <= '0;
      crc_reg       <= CRC8_INIT;
      crcFail_reg   <= 1'b0;
      cfgStrobe_reg <= 1'b0;
      cfgIndex_reg  <= '0;
      cfgWord_reg   <= '0;
    end else begin
      boot_reg      <= boot_next;
      bootDone_reg  <= (boot_next == ST_RUN);
      cnt_reg       <= cnt_next;
      dataValid_reg <= loading;
      dataIdx_reg   <= cnt_reg;
      crc_reg       <= crc_next;
      crcFail_reg   <= crcFail_next;
      cfgStrobe_reg <= dataIsCfg;
      cfgIndex_reg  <= dataIsCfg ? dataIdx_reg : cfgIndex_reg;
      cfgWord_reg   <= dataIsCfg ? memData : cfgWord_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rstAll) begin
      sleep_reg      <= 1'b0;
      temp_reg       <= RESULT_RESET;
      press_reg      <= RESULT_RESET;
      tempValid_reg  <= 1'b0;
      pressValid_reg <= 1'b0;
      liveEvt_reg    <= LIVE_RESET;
      snapPress_reg  <= 1'b0;
      snapTemp_reg   <= 1'b0;
      rdData_reg     <= READ_UNMAPPED;
    end else begin
      sleep_reg      <= sleep_reg | cmdSleep;
      temp_reg       <= tempTake ? tempData : temp_reg;
      press_reg      <= pressTake ? pressData : press_reg;
      tempValid_reg  <= tempValid_reg | tempTake;
      pressValid_reg <= pressValid_reg | pressTake;
      liveEvt_reg    <= liveEvt_next;
      snapPress_reg  <= readPress ? liveView[BIT_PRESS_UP] : snapPress_reg;
      snapTemp_reg   <= readTemp ? liveView[BIT_TEMP_UP] : snapTemp_reg;
      rdData_reg     <= regRead ? rdNext : rdData_reg;
    end
  end

  assign regRdata   = rdData_reg;
  assign sleepMode  = sleep_reg;
  assign bootDone   = bootDone_reg;
  assign cfgCrcFail = crcFail_reg;
  assign tempValid  = tempValid_reg;
  assign pressValid = pressValid_reg;
  assign cfgStrobe  = cfgStrobe_reg;
  assign cfgIndex   = cfgIndex_reg;
  assign cfgWord    = cfgWord_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rstAll);

  a_sleep_cmd: assert property (cmdSleep |=> sleepMode [*3])
    else $error("sleep command did not enter sleep");
  a_reset_cmd: assert property (disable iff (reset)
    (cmdReset && !softReset_reg) |=> softReset_reg ##1 (!bootDone && cnt_reg == '0))
    else $error("reset command did not restart power-up");
  a_boot_time: assert property ($fell(rstAll) |-> ##[BOOT_CYC:BOOT_CYC] bootDone)
    else $error("power-up load did not finish on time");
  a_temp_update: assert property (tempTake |=>
    liveEvt_reg[BIT_TEMP_UP] && temp_reg == $past(tempData))
    else $error("temperature result or flag not updated");
  a_press_update: assert property (pressTake |=>
    liveEvt_reg[BIT_PRESS_UP] && press_reg == $past(pressData))
    else $error("pressure result or flag not updated");
  a_valid_hold: assert property ((!pressValid_reg && !pressNew) |=> !pressValid_reg)
    else $error("pressure marked valid without a measurement");
  a_crc_block: assert property (cfgCrcFail |=> $stable(temp_reg) && $stable(press_reg))
    else $error("results changed after configuration check failure");
  a_snap_press: assert property (readPress |=>
    snapPress_reg == $past(liveEvt_reg[BIT_PRESS_UP]))
    else $error("pressure flag not copied to snapshot");
  a_snap_temp: assert property (readTemp |=>
    snapTemp_reg == $past(liveEvt_reg[BIT_TEMP_UP]))
    else $error("temperature flag not copied to snapshot");
  a_read_clear: assert property ((readTemp && !tempTake) |=> !liveEvt_reg[BIT_TEMP_UP])
    else $error("temperature flag not cleared by read");
  a_event_sticky: assert property ((liveEvt_reg[BIT_SUPPLY_FAULT]
    && !(hitLiveWr && regWdata[BIT_SUPPLY_FAULT])) |=> liveEvt_reg[BIT_SUPPLY_FAULT])
    else $error("event flag dropped without a clearing write");
  a_write_protect: assert property ((regWrite && regAddr == OFS_TEMP && !tempTake)
    |=> $stable(temp_reg))
    else $error("host write changed a read-only result");

  c_sleep: cover property (cmdSleep);
  c_crc_fail: cover property ($rose(cfgCrcFail));
  c_snap_copy: cover property (readPress && liveEvt_reg[BIT_PRESS_UP]);
  c_both_valid: cover property ($rose(tempValid_reg && pressValid_reg));

endmodule

//--- psrb_host_model.sv
// psrb_host_model: serial host that issues 16-bit register accesses.
// assumes the frame decoder turns each frame into one-cycle strobes.
`timescale 1ns/10ps
module psrb_host_model (
  // clock
  input  wire logic                        clk_sys,
  // register port
  output logic [psrb_pkg::ADDR_W-1:0] regAddr,
  output logic                        regWrite,
  output logic                        regRead,
  output logic [psrb_pkg::DATA_W-1:0] regWdata
);
  import psrb_pkg::*;
  initial begin
    regAddr  = 8'h00;
    regWrite = 1'b0;
    regRead  = 1'b0;
    regWdata = 16'h0000;
  end
  // an idle cycle follows each access so no strobe toggles twice in a step
  task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= wr;
    regRead  <= !wr;
    @(negedge clk_sys);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    // released lines must not keep the last value
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask
endmodule

//--- tb_psrb_regs.sv
// tb_psrb_regs: self-checking bench for the sensor register bank.
// assumes a second bank built with a corrupted image to see the crc path.
`timescale 1ns/10ps
module tb_psrb_regs;
  import psrb_pkg::*;
  logic clk_sys, reset, tempNew, pressNew, chipIdle, supplyFault;
  logic [DATA_W-1:0] tempData, pressData, expT, expP, regWdata, regRdata;
  logic [ADDR_W-1:0] regAddr;
  logic regWrite, regRead, sleepMode, bootDone, tempValid, pressValid;
  logic crcFailBad, tempValidBad;
  logic dspSat, checkFault, crcErr, cfgStrobe;
  logic bootSeen = 1'b0;
  logic [CFG_W-1:0] cfgIndex;
  logic [DATA_W-1:0] cfgWord;
  int cfgSeen = 0;
  logic readDly = 1'b0;
  logic [31:0] seed = 32'h3507;
  int err_total = 0;
  int n_checks = 0;
  logic [DATA_W-1:0] expQ[$];

  psrb_host_model u_psrb_host_model (.clk_sys(clk_sys), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata));
  psrb_regs u_psrb_regs (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .tempNew(tempNew), .tempData(tempData), .pressNew(pressNew), .pressData(pressData),
    .chipIdle(chipIdle), .dspSaturated(dspSat), .bridgeSupplyFault(supplyFault),
    .bridgeCheckFault(checkFault), .linkCrcError(crcErr), .sleepMode(sleepMode),
    .bootDone(bootDone), .cfgCrcFail(), .tempValid(tempValid), .pressValid(pressValid),
    .cfgStrobe(cfgStrobe), .cfgIndex(cfgIndex), .cfgWord(cfgWord));
  // corrupted first word so the stored check byte no longer matches
  psrb_regs #(.CFG_IMAGE(cfgDefaultImage() ^ 128'h1)) u_psrb_regs2 (.clk_sys(clk_sys),
    .reset(reset), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(), .tempNew(tempNew), .tempData(tempData),
    .pressNew(pressNew), .pressData(pressData), .chipIdle(chipIdle), .dspSaturated(dspSat),
    .bridgeSupplyFault(supplyFault), .bridgeCheckFault(checkFault), .linkCrcError(crcErr),
    .sleepMode(), .bootDone(), .cfgCrcFail(crcFailBad), .tempValid(tempValidBad),
    .pressValid(), .cfgStrobe(), .cfgIndex(), .cfgWord());

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmpBit(input string n, input logic s, input logic e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %b got %b", n, e, s);
    end
  endtask
  task automatic cmpWord(input string n, input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    expQ.push_back(e);
    u_psrb_host_model.acc(1'b0, a, 16'h0000);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    u_psrb_host_model.acc(1'b1, a, d);
  endtask
  task automatic waitBoot();
    int n = 0;
    while (bootDone !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    cmpBit("bootDone", bootDone, 1'b1);
  endtask
  task automatic feed();
    expP = DATA_W'(xs());
    expT = DATA_W'(xs());
    @(negedge clk_sys);
    pressData   <= expP;
    tempData    <= expT;
    pressNew    <= 1'b1;
    tempNew     <= 1'b1;
    supplyFault <= 1'b1;
    checkFault  <= 1'b1;
    crcErr      <= 1'b1;
    @(negedge clk_sys);
    pressNew    <= 1'b0;
    tempNew     <= 1'b0;
    supplyFault <= 1'b0;
    checkFault  <= 1'b0;
    crcErr      <= 1'b0;
    pressData   <= ~expP;
    tempData    <= ~expT;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // read data lands one edge after the strobe
  always @(posedge clk_sys) readDly <= regRead;
  always @(negedge clk_sys) begin
    if (readDly === 1'b1 && expQ.size() > 0) begin
      cmpWord("regRdata", regRdata, expQ.pop_front());
    end
  end

  // config words leave in index order, seven strobes per power-up
  always @(negedge clk_sys) begin
    if (cfgStrobe === 1'b1) begin
      cmpWord("cfgWord", cfgWord, 16'h1000 + DATA_W'(cfgSeen * 16'h0111));
      cmpWord("cfgIndex", DATA_W'(cfgIndex), DATA_W'(cfgSeen));
      cfgSeen++;
    end
    if (bootDone === 1'b1 && bootSeen !== 1'b1) begin
      cmpWord("cfgCount", DATA_W'(cfgSeen), DATA_W'(CFG_DEPTH - 1));
      cfgSeen = 0;
    end
    bootSeen = bootDone;
  end

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // whole run is under a hundred cycles
  initial begin
    #(20 * 4000);
    err_total++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    tempNew = 1'b0;
    pressNew = 1'b0;
    chipIdle = 1'b1;
    supplyFault = 1'b0;
    dspSat = 1'b0;
    checkFault = 1'b0;
    crcErr = 1'b0;
    tempData = 16'h0000;
    pressData = 16'h0000;
    repeat (8) @(negedge clk_sys);
    reset <= 1'b0;
    rd(OFS_PRESS, RESULT_RESET);
    rd(OFS_COMMAND, READ_UNMAPPED);
    rd(8'h40, READ_UNMAPPED);
    waitBoot();
    cmpBit("cfgCrcFail", crcFailBad, 1'b1);
    $display("test boot done");
    dspSat <= 1'b1;
    feed();
    cmpBit("tempValid", tempValid, 1'b1);
    cmpBit("tempValidBad", tempValidBad, 1'b0);
    rd(OFS_LIVE, 16'h0D99);
    wr(OFS_PRESS, DATA_W'(xs()));
    wr(OFS_TEMP, DATA_W'(xs()));
    wr(OFS_SNAP, 16'hFFFF);
    rd(OFS_PRESS, expP);
    rd(OFS_SNAP, 16'h0D89);
    rd(OFS_TEMP, expT);
    rd(OFS_SNAP, 16'h0D99);
    rd(OFS_LIVE, 16'h0D81);
    wr(OFS_LIVE, 16'hFFFF);
    rd(OFS_SNAP, 16'h0419);
    rd(OFS_LIVE, 16'h0401);
    dspSat <= 1'b0;
    // second result while the up flags still stand marks both as missed
    feed();
    feed();
    rd(OFS_LIVE, 16'hC999);
    rd(OFS_PRESS, expP);
    wr(OFS_LIVE, 16'hFFFF);
    rd(OFS_LIVE, 16'h0001);
    $display("test results done");
    wr(OFS_COMMAND, 16'h1234);
    cmpBit("sleepMode", sleepMode, 1'b0);
    wr(OFS_COMMAND, CMD_SLEEP);
    cmpBit("sleepMode", sleepMode, 1'b1);
    wr(OFS_COMMAND, CMD_RESET);
    @(negedge clk_sys);
    cmpBit("bootDone", bootDone, 1'b0);
    waitBoot();
    cmpBit("sleepMode", sleepMode, 1'b0);
    cmpBit("pressValid", pressValid, 1'b0);
    rd(OFS_PRESS, RESULT_RESET);
    @(negedge clk_sys);
    $display("test commands done");
    end_sim();
  end
endmodule
